//--- include/region_prot_pkg.sv
package region_prot_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam logic [7:0] SEL_OFS = 8'h08;
   localparam logic [7:0] BASE_OFS = 8'h0c;
   localparam logic [7:0] ATTR_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] MASK_OFS = 8'h18;
   localparam logic [7:0] FADDR_OFS = 8'h1c;

   // Control bits
   localparam int PROT_ON_BIT = 0;
   localparam int PRIV_BG_BIT = 1;
   localparam int FAULT_HND_BIT = 2;

   // Attribute field positions
   localparam int ATTR_ON_BIT = 0;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_SUB_LSB = 8;
   localparam int ATTR_PERM_LSB = 24;
   localparam int ATTR_XN_BIT = 28;
   localparam logic [31:0] ATTR_WMASK = 32'h170_0ff3f;

   // Size code n gives 2^(n+1) bytes; 4 is 32 bytes, 31 is 4 GB
   localparam logic [4:0] SIZE_32_BYTES = 5'h04;
   localparam logic [4:0] SIZE_4_GIGABYTES = 5'h1f;
   localparam logic [4:0] SIZE_256_BYTES = 5'h07;

   // Permission encodings, privileged/user
   localparam logic [2:0] PERM_NONE_NONE = 3'h0;
   localparam logic [2:0] PERM_RW_NONE = 3'h1;
   localparam logic [2:0] PERM_RW_RO = 3'h2;
   localparam logic [2:0] PERM_RW_RW = 3'h3;
   localparam logic [2:0] PERM_RO_NONE = 3'h5;
   localparam logic [2:0] PERM_RO_RO = 3'h6;

   // Status bits
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_NOMATCH_BIT = 1;

   localparam logic [31:0] CTRL_RESET = 32'h0;
   localparam logic [31:0] ATTR_RESET = 32'h0;

endpackage : region_prot_pkg

//--- src/region_memory_protection.sv
`timescale 1ns/1ps
module region_memory_protection
   import region_prot_pkg::*;
#(
   parameter int NUM_REGIONS = 8
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [31:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_WE_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic WB_ACK_O,
   input wire logic ACC_VALID,
   input wire logic [31:0] ACC_ADDR,
   input wire logic ACC_WRITE,
   input wire logic ACC_FETCH,
   input wire logic ACC_PRIV,
   input wire logic ACC_IN_FAULT_HANDLER,
   output logic ACC_FAULT,
   output logic ACC_DEFAULT_MAP,
   output logic IRQ
);

   localparam int IDX_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

   logic [31:0] ctrl_reg;
   logic [IDX_W-1:0] sel_reg;
   logic [31:0] base_reg [NUM_REGIONS];
   logic [31:0] attr_reg [NUM_REGIONS];
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   logic [31:0] faddr_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic fault_reg;
   logic default_map_reg;
   logic irq_reg;

   logic wr_req;
   logic [31:0] wmask_sel;
   logic [31:0] attr_next;
   logic [31:0] attr_cur;
   logic [1:0] mask_next;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, ack then drop for a cycle

   // Writes land on the acked edge, never before the master sees the answer
   assign wr_req = WB_CYC_I && WB_STB_I && WB_WE_I && ack_reg;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask_sel[b*8 +: 8] = WB_SEL_I[b] ? 8'hff : 8'h00;
      end
   end

   // Registered ack gives every request exactly one wait state
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_req && WB_ADR_I[7:0] == CTRL_OFS) begin
         // Only the three option bits exist; the rest read back as zero
         ctrl_reg <= ((ctrl_reg & ~wmask_sel) | (WB_DAT_I & wmask_sel)) & 32'h0000_0007;
      end
   end

   // Index is cut to the counter width; keep the region count a power of two
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         sel_reg <= '0;
      end else if (wr_req && WB_ADR_I[7:0] == SEL_OFS && WB_SEL_I[0]) begin
         sel_reg <= WB_DAT_I[IDX_W-1:0];
      end
   end

   assign mask_next = (wr_req && WB_ADR_I[7:0] == MASK_OFS && WB_SEL_I[0]) ? WB_DAT_I[1:0]
                      : mask_reg;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         mask_reg <= 2'h0;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Masked write keeps the rest of the region untouched
   assign attr_cur = attr_reg[sel_reg];
   assign attr_next = ((attr_cur & ~wmask_sel) | (WB_DAT_I & wmask_sel)) & ATTR_WMASK;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         for (int r = 0; r < NUM_REGIONS; r++) begin
            base_reg[r] <= 32'h0;
         end
      end else if (wr_req && WB_ADR_I[7:0] == BASE_OFS) begin
         // Low five bits never hold address; smallest region is 32 bytes
         base_reg[sel_reg] <= ((base_reg[sel_reg] & ~wmask_sel) | (WB_DAT_I & wmask_sel))
                              & 32'hffff_ffe0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         for (int r = 0; r < NUM_REGIONS; r++) begin
            attr_reg[r] <= ATTR_RESET;
         end
      end else if (wr_req && WB_ADR_I[7:0] == ATTR_OFS) begin
         // Enable bit lives in the same word as the attributes
         attr_reg[sel_reg] <= attr_next;
      end
   end

   // Address holds through the wait state, so the data is ready with ack
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         rdata_reg <= 32'h0;
      end else begin
         unique case (WB_ADR_I[7:0])
            CTRL_OFS: rdata_reg <= ctrl_reg;
            COUNT_OFS: rdata_reg <= 32'(NUM_REGIONS);
            SEL_OFS: rdata_reg <= 32'(sel_reg);
            BASE_OFS: rdata_reg <= base_reg[sel_reg];
            ATTR_OFS: rdata_reg <= attr_cur;
            STATUS_OFS: rdata_reg <= {30'h0, status_reg};
            MASK_OFS: rdata_reg <= {30'h0, mask_reg};
            FADDR_OFS: rdata_reg <= faddr_reg;
            default: rdata_reg <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Region match and permission check

   logic [NUM_REGIONS-1:0] hit;
   logic any_hit;
   logic [2:0] win_perm;
   logic win_xn;
   logic chk_on;
   logic violate;
   logic nomatch_fault;

   always_comb begin
      for (int r = 0; r < NUM_REGIONS; r++) begin
         logic [4:0] sz;
         logic [31:0] lim_mask;
         logic [2:0] sub_idx;
         logic sub_off;
         lim_mask = 32'h0;
         sub_idx = 3'h0;
         sub_off = 1'b0;
         sz = attr_reg[r][ATTR_SIZE_LSB +: 5];
         // Codes below 32 bytes are clamped, never smaller than the floor
         if (sz < SIZE_32_BYTES) begin
            sz = SIZE_32_BYTES;
         end
         lim_mask = (sz == SIZE_4_GIGABYTES) ? 32'hffff_ffff
                    : ((32'h2 << sz) - 32'h1);
         // A region of 2^(n+1) bytes has eighths of 2^(n-2) bytes
         sub_idx = 3'((ACC_ADDR & lim_mask) >> (sz - 5'h2));
         sub_off = (sz >= SIZE_256_BYTES)
                   && attr_reg[r][ATTR_SUB_LSB + 32'(sub_idx)];
         hit[r] = attr_reg[r][ATTR_ON_BIT]
                  && ((ACC_ADDR & ~lim_mask) == (base_reg[r] & ~lim_mask))
                  && !sub_off;
      end
   end

   // Later regions overwrite earlier ones, so the top hit wins
   always_comb begin
      any_hit = 1'b0;
      win_perm = PERM_NONE_NONE;
      win_xn = 1'b0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
         if (hit[r]) begin
            any_hit = 1'b1;
            win_perm = attr_reg[r][ATTR_PERM_LSB +: 3];
            win_xn = attr_reg[r][ATTR_XN_BIT];
         end
      end
   end

   always_comb begin
      logic p_rd;
      logic p_wr;
      p_rd = 1'b0;
      p_wr = 1'b0;
      unique case (win_perm)
         PERM_RW_NONE: begin
            p_rd = ACC_PRIV;
            p_wr = ACC_PRIV;
         end
         PERM_RW_RO: begin
            p_rd = 1'b1;
            p_wr = ACC_PRIV;
         end
         PERM_RW_RW: begin
            p_rd = 1'b1;
            p_wr = 1'b1;
         end
         PERM_RO_NONE: begin
            p_rd = ACC_PRIV;
            p_wr = 1'b0;
         end
         PERM_RO_RO: begin
            p_rd = 1'b1;
            p_wr = 1'b0;
         end
         default: begin
            p_rd = 1'b0;
            p_wr = 1'b0;
         end
      endcase
      // Fetches need read access and execute permission
      violate = any_hit && ((ACC_FETCH && (win_xn || !p_rd))
                || (!ACC_FETCH && (ACC_WRITE ? !p_wr : !p_rd)));
   end

   assign chk_on = ctrl_reg[PROT_ON_BIT]
                   && (!ACC_IN_FAULT_HANDLER || ctrl_reg[FAULT_HND_BIT]);
   assign nomatch_fault = !any_hit && !(ACC_PRIV && ctrl_reg[PRIV_BG_BIT]);

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         fault_reg <= 1'b0;
         default_map_reg <= 1'b1;
      end else begin
         fault_reg <= ACC_VALID && chk_on && (violate || nomatch_fault);
         // Tracks every cycle, valid or not, so the core may look at it any time
         default_map_reg <= !chk_on || (!any_hit && ACC_PRIV && ctrl_reg[PRIV_BG_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats the clear

   logic [1:0] ev;
   logic [1:0] clr;
   logic [1:0] status_next;
   assign ev[ST_FAULT_BIT] = ACC_VALID && chk_on && violate;
   assign ev[ST_NOMATCH_BIT] = ACC_VALID && chk_on && !violate && nomatch_fault;
   assign clr = (wr_req && WB_ADR_I[7:0] == STATUS_OFS && WB_SEL_I[0]) ? WB_DAT_I[1:0]
                : 2'h0;
   assign status_next = (status_reg & ~clr) | ev;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         status_reg <= 2'h0;
         faddr_reg <= 32'h0;
      end else begin
         status_reg <= status_next;
         if (|ev) begin
            faddr_reg <= ACC_ADDR;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         irq_reg <= 1'b0;
      end else begin
         // Next values, so a mask or clear write acts on its own acked edge
         irq_reg <= |(status_next & mask_next);
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;
   assign ACC_FAULT = fault_reg;
   assign ACC_DEFAULT_MAP = default_map_reg;
   assign IRQ = irq_reg;

endmodule : region_memory_protection

//--- testbench/region_prot_asserts.sv
`timescale 1ns/1ps
module region_prot_asserts (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic WB_WE_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic ACC_VALID,
   input wire logic ACC_FAULT,
   input wire logic ACC_DEFAULT_MAP,
   input wire logic IRQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   ////////////////////////////////////////////////////////////////
   a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("no ack after request");
   a_ack_single_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held too long");
   a_ack_needs_req: assert property (!WB_STB_I |=> !WB_ACK_O)
      else $error("ack without request");
   a_fault_needs_access: assert property (ACC_FAULT |-> $past(ACC_VALID))
      else $error("fault without access");
   a_default_no_fault: assert property (ACC_DEFAULT_MAP |-> !ACC_FAULT)
      else $error("fault under default map");
   a_reset_outputs_idle: assert property ($fell(SYS_RST) |->
      ACC_DEFAULT_MAP && !ACC_FAULT && !IRQ && !WB_ACK_O) else $error("bad state after reset");
   // Only a register write may lower the level
   a_irq_holds_high: assert property (IRQ && !(WB_STB_I && WB_WE_I) |=> IRQ)
      else $error("irq dropped without write");
   a_irq_rise_cause: assert property ($rose(IRQ) |->
      $past(ACC_VALID) || ($past(WB_STB_I) && $past(WB_WE_I))) else $error("irq rose alone");
   cover property (ACC_FAULT);
   cover property ($fell(IRQ));
   cover property (ACC_DEFAULT_MAP && ACC_VALID);
endmodule : region_prot_asserts
////////////////////////////////////////////////////////////////
bind region_memory_protection region_prot_asserts region_prot_asserts_i (
   .SYS_CLK, .SYS_RST, .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
   .ACC_VALID, .ACC_FAULT, .ACC_DEFAULT_MAP, .IRQ);

//--- testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
   input wire logic clk,
   output logic valid,
   output logic [31:0] addr,
   output logic write,
   output logic fetch,
   output logic priv,
   output logic handler
);
   initial begin
      valid = 1'b0;
      addr = 32'h0;
      {write, fetch, priv, handler} = 4'h0;
   end
   // Kind is {write, fetch, priv, handler}; one access per call
   task automatic access(input logic [31:0] a, input logic [3:0] k);
      @(posedge clk);
      valid <= 1'b1;
      addr <= a;
      {write, fetch, priv, handler} <= k;
      @(posedge clk);
      valid <= 1'b0;
      // Idle bus must not look like the last address
      addr <= ~a;
   endtask : access
endmodule : core_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %0h seen %0h", n, e, g); end end
module testbench;
   import region_prot_pkg::*;
   localparam int NREG = 8;
   localparam logic [3:0] UR = 4'h0, UW = 4'h8, PR = 4'h2, PW = 4'ha, PF = 4'h6, UH = 4'h1;
   localparam logic [1:0] OK = 2'b00, FLT = 2'b10, DEF = 2'b01;
   logic SYS_CLK = 1'b0, SYS_RST = 1'b1, WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
   logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, WB_DAT_O, ACC_ADDR;
   logic [3:0] WB_SEL_I = 4'hf;
   logic WB_ACK_O, ACC_VALID, ACC_WRITE, ACC_FETCH, ACC_PRIV, ACC_IN_FAULT_HANDLER;
   logic ACC_FAULT, ACC_DEFAULT_MAP, IRQ;
   logic [3:0] kinds [4] = '{PR, PW, UR, UW};
   logic [2:0] perms [6] = '{PERM_NONE_NONE, PERM_RW_NONE, PERM_RW_RO, PERM_RW_RW,
      PERM_RO_NONE, PERM_RO_RO};
   logic [3:0] allow [6] = '{4'b0000, 4'b1100, 4'b1110, 4'b1111, 4'b1000, 4'b1010};
   int fails = 0;
   int compares = 0;
   always #2.5 SYS_CLK = ~SYS_CLK;
   region_memory_protection #(.NUM_REGIONS(NREG)) region_memory_protection_i (
      .SYS_CLK, .SYS_RST, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_SEL_I, .WB_WE_I, .WB_CYC_I,
      .WB_STB_I, .WB_ACK_O, .ACC_VALID, .ACC_ADDR, .ACC_WRITE, .ACC_FETCH, .ACC_PRIV,
      .ACC_IN_FAULT_HANDLER, .ACC_FAULT, .ACC_DEFAULT_MAP, .IRQ);
   core_model core_model_i (.clk(SYS_CLK), .valid(ACC_VALID), .addr(ACC_ADDR),
      .write(ACC_WRITE), .fetch(ACC_FETCH), .priv(ACC_PRIV), .handler(ACC_IN_FAULT_HANDLER));
   ////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge SYS_CLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, w};
      WB_ADR_I <= {24'h0, a};
      WB_DAT_I <= d;
      WB_SEL_I <= 4'hf;
      do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      {WB_CYC_I, WB_STB_I} <= 2'b00;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      `CHK($sformatf("reg %h", a), e, q)
   endtask : rd
   task automatic acc(input logic [31:0] a, input logic [3:0] k, input logic [1:0] e);
      core_model_i.access(a, k);
      #1;
      `CHK($sformatf("access %h", a), e, {ACC_FAULT, ACC_DEFAULT_MAP})
   endtask : acc
   function automatic logic [31:0] attr(logic [4:0] sz, logic [7:0] sub, logic [2:0] p,
      logic xn, logic on);
      return ({27'h0, sz} << ATTR_SIZE_LSB) | ({24'h0, sub} << ATTR_SUB_LSB)
         | ({29'h0, p} << ATTR_PERM_LSB) | ({31'h0, xn} << ATTR_XN_BIT) | {31'h0, on};
   endfunction : attr
   task automatic region(input logic [31:0] i, input logic [31:0] b, input logic [31:0] at);
      wr(SEL_OFS, i);
      wr(BASE_OFS, b);
      wr(ATTR_OFS, at);
   endtask : region
   task automatic conclude;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      fails++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      rd(CTRL_OFS, CTRL_RESET);
      rd(COUNT_OFS, NREG);
      rd(ATTR_OFS, ATTR_RESET);
      rd(8'h20, 32'h0);
      acc(32'h4000_0000, UR, DEF);
      region(0, 32'h4000_0000, attr(5'h13, 8'h12, PERM_RW_NONE, 1'b1, 1'b1));
      region(1, 32'h4008_0000, attr(5'h10, 8'h00, PERM_RW_RW, 1'b1, 1'b1));
      rd(ATTR_OFS, attr(5'h10, 8'h00, PERM_RW_RW, 1'b1, 1'b1));
      wr(CTRL_OFS, 32'h1);
      acc(32'h4000_0000, PR, OK);
      acc(32'h4000_0000, UR, FLT);
      acc(32'h4000_0000, PF, FLT);
      acc(32'h4000_0000, PW, OK);
      acc(32'h4002_0000, PR, FLT);
      acc(32'h4001_fffc, PR, OK);
      acc(32'h4009_fffc, UW, OK);
      acc(32'h400a_0000, UW, FLT);
      acc(32'h400f_fffc, PW, OK);
      acc(32'h4010_0000, PR, FLT);
      rd(STATUS_OFS, 32'h3);
      rd(FADDR_OFS, 32'h4010_0000);
      #1;
      `CHK("irq", 1'b0, IRQ)
      wr(MASK_OFS, 32'h3);
      #1;
      `CHK("irq", 1'b1, IRQ)
      wr(STATUS_OFS, 32'h1);
      rd(STATUS_OFS, 32'h2);
      wr(MASK_OFS, 32'h1);
      #1;
      `CHK("irq", 1'b0, IRQ)
      wr(STATUS_OFS, 32'h2);
      rd(STATUS_OFS, 32'h0);
      foreach (perms[i]) begin
         wr(ATTR_OFS, attr(5'h10, 8'h00, perms[i], 1'b1, 1'b0));
         wr(ATTR_OFS, attr(5'h10, 8'h00, perms[i], 1'b1, 1'b1));
         foreach (kinds[j])
            acc(32'h4008_0000, kinds[j], allow[i][3 - j] ? OK : FLT);
      end
      wr(SEL_OFS, 32'h0);
      wr(ATTR_OFS, attr(5'h13, 8'h02, PERM_RW_NONE, 1'b1, 1'b0));
      wr(ATTR_OFS, attr(5'h13, 8'h02, PERM_RW_NONE, 1'b1, 1'b1));
      acc(32'h4008_0000, UR, OK);
      region(2, 32'h5000_0000, attr(SIZE_32_BYTES, 8'hff, PERM_RW_RW, 1'b0, 1'b1));
      acc(32'h5000_0000, UR, OK);
      acc(32'h5000_0020, UR, FLT);
      wr(ATTR_OFS, attr(SIZE_32_BYTES, 8'hff, PERM_RW_RW, 1'b0, 1'b0));
      acc(32'h5000_0000, UR, FLT);
      rd(BASE_OFS, 32'h5000_0000);
      wr(ATTR_OFS, attr(SIZE_32_BYTES, 8'hff, PERM_RW_RW, 1'b0, 1'b1));
      acc(32'h5000_0000, UR, OK);
      wr(CTRL_OFS, 32'h3);
      acc(32'h6000_0000, PR, DEF);
      acc(32'h6000_0000, UR, FLT);
      acc(32'h6000_0000, UH, DEF);
      wr(CTRL_OFS, 32'h5);
      acc(32'h6000_0000, UH, FLT);
      conclude();
   end
endmodule : testbench
